// file: verilog/reset_source_prioritizer.v
// reset source prioritizer with axi4-lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "reset_prioritizer_regs.vh"
// Operation
// - every reset type resets cpu, peripherals, debug and port control
// - por and sleep wake-up clear sram; stop wake-up leaves sram untouched
// - pin, window watchdog, system watchdog and soft resets leave sram alone
// - pin or window watchdog reset during sram write may corrupt that byte
// - memory extension stack ram is reset by every reset type
// - pin, window watchdog and wake-up act like power-on reset
// - system watchdog and soft resets keep requestor bit, boot config, nmi flags
// - system watchdog and soft resets keep clock system and pll settings
// - nvm reset by all types; map ram kept on watchdog and soft resets
// - firmware init full, most, or skipped depending on reset type
// - soft reset raised by the system reset request bit
// - priority: por, wake-up, pin, window watchdog, then watchdog and soft
// - wake-up reset comes from enabled wake pin event in power-save mode
// - separate indicator bits for sleep and stop wake-up
// - any wake-up from sleep always resets the device
// - reset pin active low; in power-save mode it becomes a wake-up
// - reset pin filter time programmed by blind time register
// - window watchdog reset on overflow or closed-window service
// - por, wake, pin, window watchdog reset select pll clock in user mode
// - boot config latched on all resets except system watchdog and soft
module reset_source_prioritizer #(
  parameter BOOT_W = 3,
  parameter WAKE_W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire por_req,
  input wire [WAKE_W-1:0] wake_pin,
  input wire [WAKE_W-1:0] wake_enable,
  input wire in_sleep,
  input wire in_stop,
  input wire reset_pin_n,
  input wire winwdt_overflow,
  input wire winwdt_closed_service,
  input wire syswdt_overflow,
  input wire [BOOT_W-1:0] boot_pins,
  input wire sram_write_active,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg core_reset,
  output reg periph_reset,
  output reg debug_reset,
  output reg port_reset,
  output reg nvm_reset,
  output reg map_ram_reset,
  output reg sram_clear,
  output reg sram_byte_undefined,
  output reg stack_ram_reset,
  output reg clock_reset,
  output reg pll_select,
  output reg nmi_clear,
  output reg [1:0] fw_init_level,
  output reg [BOOT_W-1:0] boot_config,
  output reg [2:0] effective_reset
);

  // registers
  reg [7:0] status;
  reg [7:0] blind_time;
  reg user_mode;
  reg soft_req;
  reg [7:0] pin_cnt;
  reg pin_asserted;
  reg [7:0] pulse_cnt;
  reg [2:0] next_eff;
  reg [7:0] next_set;
  reg aw_hold;
  reg w_hold;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire write_go;
  wire pwr_save;
  wire wake_event;
  wire pin_req;
  wire winwdt_req;
  wire wake_any;

  // rank a set of request lines into one effective type
  function [2:0] rank;
    input por;
    input wake;
    input pin;
    input win;
    input low;
    begin
      if (por)
        rank = `EFF_POR;
      else if (wake)
        rank = `EFF_WAKE;
      else if (pin)
        rank = `EFF_PIN;
      else if (win)
        rank = `EFF_WINWDT;
      else if (low)
        rank = `EFF_SOFT;
      else
        rank = `EFF_NONE;
    end
  endfunction

  // pulse length sized to the counter here, so the load never drops bits
  // from the wide constant expression
  localparam [7:0] PULSE_LEN = `PULSE_CYC;

  // firmware start-up depth per effective type
  // cold and wake starts rebuild everything; pin and window watchdog starts
  // redo most of it, and the two low-level types skip it
  function [1:0] init_level;
    input [2:0] eff;
    begin
      case (eff)
        `EFF_POR: init_level = `INIT_FULL;
        `EFF_WAKE: init_level = `INIT_FULL;
        `EFF_PIN: init_level = `INIT_MOST;
        `EFF_WINWDT: init_level = `INIT_MOST;
        `EFF_SOFT: init_level = `INIT_SKIP;
        default: init_level = `INIT_FULL;
      endcase
    end
  endfunction

  // sram is wiped only on a cold start or a wake from sleep
  // both lose the ram supply, so its contents are garbage anyway;
  // a stop wake keeps power and must leave the data alone
  function clears_sram;
    input [2:0] eff;
    input sleep;
    begin
      clears_sram = (eff == `EFF_POR) || (eff == `EFF_WAKE && sleep);
    end
  endfunction

  // types that may cut a running sram write short
  // the targeted byte is then flagged, never repaired
  function cuts_write;
    input [2:0] eff;
    begin
      cuts_write = (eff == `EFF_PIN) || (eff == `EFF_WINWDT);
    end
  endfunction

  // low-level types keep clock, map ram, nmi flags and boot setup
  // so the core restarts on the clock setup it already had
  function keeps_setup;
    input [2:0] eff;
    begin
      keeps_setup = (eff == `EFF_SOFT);
    end
  endfunction

  // writable offsets; the effect register is read-only
  // a write elsewhere gets an error response and changes nothing
  function reg_writable;
    input [3:0] addr;
    begin
      reg_writable = (addr == `ADDR_STATUS) || (addr == `ADDR_CTRL) ||
                     (addr == `ADDR_BLIND);
    end
  endfunction

  assign pwr_save = in_sleep | in_stop;
  assign wake_event = pwr_save & (|(wake_pin & wake_enable));
  // pin assertion during power-save counts as a wake-up, not a pin reset
  assign wake_any = wake_event | (pin_asserted & pwr_save);
  assign pin_req = pin_asserted & ~pwr_save;
  assign winwdt_req = winwdt_overflow | winwdt_closed_service;

  // reset pin blind filter: low must persist past the programmed time
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt <= 8'h00;
      pin_asserted <= 1'b0;
    end else if (reset_pin_n) begin
      pin_cnt <= 8'h00;
      pin_asserted <= 1'b0;
    end else if (pin_cnt >= blind_time) begin
      pin_asserted <= 1'b1;
    end else begin
      pin_cnt <= pin_cnt + 8'h01;
    end
  end

  // which sources are active this cycle and which effect wins
  always @* begin
    next_set = 8'h00;
    next_set[`ST_POR] = por_req;
    next_set[`ST_WAKE_SLEEP] = wake_any & in_sleep;
    next_set[`ST_WAKE_STOP] = wake_any & ~in_sleep;
    next_set[`ST_PIN] = pin_asserted;
    next_set[`ST_WINWDT] = winwdt_req;
    next_set[`ST_SYSWDT] = syswdt_overflow;
    next_set[`ST_SOFT] = soft_req;
    next_eff = rank(por_req, wake_any, pin_req, winwdt_req,
                    syswdt_overflow | soft_req);
  end

  // reset effect generation; one pulse of fixed length, started when a request is seen while no pulse runs
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt <= 8'h00;
      effective_reset <= `EFF_NONE;
      core_reset <= 1'b0;
      periph_reset <= 1'b0;
      debug_reset <= 1'b0;
      port_reset <= 1'b0;
      nvm_reset <= 1'b0;
      map_ram_reset <= 1'b0;
      sram_clear <= 1'b0;
      sram_byte_undefined <= 1'b0;
      stack_ram_reset <= 1'b0;
      clock_reset <= 1'b0;
      pll_select <= 1'b0;
      nmi_clear <= 1'b0;
      fw_init_level <= `INIT_FULL;
      boot_config <= {BOOT_W{1'b0}};
    end else if (next_eff != `EFF_NONE && pulse_cnt == 8'h00) begin
      pulse_cnt <= PULSE_LEN;
      effective_reset <= next_eff;
      core_reset <= 1'b1;
      periph_reset <= 1'b1;
      debug_reset <= 1'b1;
      port_reset <= 1'b1;
      nvm_reset <= 1'b1;
      stack_ram_reset <= 1'b1;
      // por and sleep wake clear ram; the others leave it
      sram_clear <= clears_sram(next_eff, in_sleep);
      sram_byte_undefined <= sram_write_active && cuts_write(next_eff);
      fw_init_level <= init_level(next_eff);
      if (keeps_setup(next_eff)) begin
        map_ram_reset <= 1'b0;
        clock_reset <= 1'b0;
        nmi_clear <= 1'b0;
      end else begin
        // hardware-equivalent to a cold power-on
        map_ram_reset <= 1'b1;
        clock_reset <= 1'b1;
        nmi_clear <= 1'b1;
        pll_select <= user_mode;
        boot_config <= boot_pins;
      end
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
      if (pulse_cnt == 8'h01) begin
        core_reset <= 1'b0;
        periph_reset <= 1'b0;
        debug_reset <= 1'b0;
        port_reset <= 1'b0;
        nvm_reset <= 1'b0;
        map_ram_reset <= 1'b0;
        sram_clear <= 1'b0;
        stack_ram_reset <= 1'b0;
        clock_reset <= 1'b0;
        nmi_clear <= 1'b0;
      end
    end
  end

  // axi write channel capture; address and data may come in either order
  assign write_go = aw_hold & w_hold & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_writable(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register updates; hardware set wins over a software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= 8'h00;
      blind_time <= `BLIND_RESET;
      user_mode <= 1'b1;
      soft_req <= 1'b0;
    end else begin
      // the request bit self-clears once any reset pulse is running
      if (soft_req && pulse_cnt != 8'h00)
        soft_req <= 1'b0;
      if (write_go && w_strb[0]) begin
        case (aw_addr)
          `ADDR_STATUS: status <= (status & ~w_data[7:0]) | next_set;
          `ADDR_CTRL: begin
            soft_req <= w_data[`CTL_SOFT_REQ];
            user_mode <= w_data[`CTL_USER_MODE];
          end
          `ADDR_BLIND: blind_time <= w_data[7:0];
          default: status <= status | next_set;
        endcase
      end
      if (!(write_go && w_strb[0] && aw_addr == `ADDR_STATUS))
        status <= status | next_set;
    end
  end

  // read channel; one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_STATUS: s_axi_rdata <= {24'h000000, status};
          `ADDR_EFFECT: s_axi_rdata <= {16'h0000, 5'h00, boot_config[2:0],
                                        3'h0, fw_init_level, effective_reset};
          `ADDR_CTRL: s_axi_rdata <= {30'h00000000, user_mode, soft_req};
          `ADDR_BLIND: s_axi_rdata <= {24'h000000, blind_time};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: common/reset_prioritizer_regs.vh
// register map, field positions, reset values and timing constants of the reset prioritizer
`ifndef RESET_PRIORITIZER_REGS_VH
`define RESET_PRIORITIZER_REGS_VH
// register byte addresses
`define ADDR_STATUS 4'h0
`define ADDR_EFFECT 4'h4
`define ADDR_CTRL 4'h8
`define ADDR_BLIND 4'hC
// status bit positions (sticky indicator bits)
`define ST_WAKE_STOP 1
`define ST_WAKE_SLEEP 2
`define ST_SOFT 3
`define ST_SYSWDT 4
`define ST_WINWDT 5
`define ST_PIN 6
`define ST_POR 7
// control bit positions
`define CTL_SOFT_REQ 0
`define CTL_USER_MODE 1
// effective reset type codes
`define EFF_NONE 3'h0
`define EFF_POR 3'h1
`define EFF_WAKE 3'h2
`define EFF_PIN 3'h3
`define EFF_WINWDT 3'h4
`define EFF_SOFT 3'h5
// firmware init levels
`define INIT_FULL 2'h0
`define INIT_MOST 2'h1
`define INIT_SKIP 2'h2
// reset values and timing
`define BLIND_RESET 8'h04
`define PULSE_NS 200
`define CLK_NS 50
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: test/reset_prio_checker.sv
// assertions on the reset prioritizer outputs
`timescale 1ns/100ps
module reset_prio_checker #(
  parameter BOOT_W = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire por_req,
  input wire [BOOT_W-1:0] boot_pins,
  input wire core_reset,
  input wire periph_reset,
  input wire debug_reset,
  input wire port_reset,
  input wire nvm_reset,
  input wire map_ram_reset,
  input wire sram_clear,
  input wire stack_ram_reset,
  input wire clock_reset,
  input wire nmi_clear,
  input wire pll_select,
  input wire [1:0] fw_init_level,
  input wire [BOOT_W-1:0] boot_config,
  input wire [2:0] effective_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_all_reset: assert property (core_reset |-> periph_reset && debug_reset && port_reset
    && nvm_reset && stack_ram_reset) else $error("reset group incomplete");
  a_soft_keep: assert property (core_reset && effective_reset == 3'h5
    |-> !clock_reset && !map_ram_reset && !nmi_clear) else $error("soft reset hit kept state");
  a_sram_only: assert property (sram_clear
    |-> effective_reset inside {3'h1, 3'h2}) else $error("sram cleared wrongly");
  a_init_level: assert property ($rose(core_reset) |-> fw_init_level ==
    (effective_reset == 3'h5 ? 2'h2 : effective_reset > 3'h2 ? 2'h1 : 2'h0))
    else $error("init level wrong");
  a_pulse_len: assert property ($rose(core_reset)
    |-> core_reset[*4] ##1 !core_reset) else $error("pulse length wrong");
  a_por_first: assert property (por_req && !core_reset
    |=> core_reset && effective_reset == 3'h1) else $error("power-on not first");
  a_soft_hold: assert property ($rose(core_reset) && effective_reset == 3'h5
    |-> $stable(boot_config) && $stable(pll_select)) else $error("soft reset changed setup");
  a_boot_latch: assert property ($rose(core_reset) && effective_reset != 3'h5
    |-> boot_config == $past(boot_pins)) else $error("boot straps not latched");
endmodule
bind reset_source_prioritizer reset_prio_checker #(.BOOT_W(BOOT_W)) chk_i (.*);

// file: test/reset_sources.sv
// far-side model: reset pin, wake pins and both watchdogs
`timescale 1ns/100ps
module reset_sources (
  input wire aclk,
  input wire [2:0] kind,
  input wire go,
  input wire [7:0] hold,
  output logic reset_pin_n,
  output logic [3:0] wake_pin,
  output logic winwdt_overflow,
  output logic winwdt_closed_service,
  output logic syswdt_overflow
);
  logic [7:0] cnt = 8'h00;
  logic [2:0] k = 3'h0;
  // one source active for hold cycles after each go
  always @(posedge aclk) begin
    if (go) begin
      k <= kind;
      cnt <= hold;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // pin has a pull-up, so release reads high
  assign reset_pin_n = !(cnt != 8'h00 && k == 3'h1);
  assign wake_pin = (cnt != 8'h00 && k == 3'h2) ? 4'h5 : 4'h0;
  assign winwdt_overflow = cnt != 8'h00 && k == 3'h3;
  assign winwdt_closed_service = cnt != 8'h00 && k == 3'h4;
  assign syswdt_overflow = cnt != 8'h00 && k == 3'h5;
endmodule

// file: test/reset_source_prioritizer_bench.sv
// self-checking bench for the reset source prioritizer
`timescale 1ns/100ps
`include "reset_prioritizer_regs.vh"
module reset_source_prioritizer_bench;
  logic aclk = 0, aresetn = 0, por_req = 0, in_sleep = 0, in_stop = 0, sram_write_active = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, go = 0, seen_clr;
  logic [3:0] wake_enable = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0;
  logic [2:0] boot_pins = 3'h5, kind = 0;
  logic [7:0] hold = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_reset;
  wire periph_reset, debug_reset, port_reset, nvm_reset, map_ram_reset, sram_clear;
  wire sram_byte_undefined, stack_ram_reset, clock_reset, pll_select, nmi_clear;
  wire reset_pin_n, winwdt_overflow, winwdt_closed_service, syswdt_overflow;
  wire [1:0] s_axi_bresp, s_axi_rresp, fw_init_level;
  wire [31:0] s_axi_rdata;
  wire [2:0] boot_config, effective_reset;
  wire [3:0] wake_pin;
  int n_mismatch = 0;
  int n_checks = 0;
  reset_source_prioritizer uut (.*);
  reset_sources src (.*);
  // 20 MHz clock
  always #25 aclk = !aclk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // write; address and data each released at their own ready
  task wr(input [3:0] a, input [31:0] d, input [1:0] e);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, e);
  endtask
  task rd(input [3:0] a, input [31:0] d, input [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, e);
  endtask
  task fire(input [2:0] k, input [7:0] h);
    @(posedge aclk);
    {kind, hold, go} <= {k, h, 1'h1};
    @(posedge aclk);
    go <= 0;
  endtask
  // bounded wait for the pulse, then judge the type
  task exp_rst(input [2:0] e, input [1:0] f);
    int i;
    i = 0;
    while (core_reset !== 1 && i < 40) begin
      @(negedge aclk);
      i++;
    end
    seen_clr = sram_clear;
    // a missing pulse must not pass on the type left by the last one
    chk(core_reset, 1);
    chk(effective_reset, e);
    chk(fw_init_level, f);
    repeat (8) @(posedge aclk);
  endtask
  task t_regs;
    chk(effective_reset, 0);
    rd(`ADDR_BLIND, 32'h4, `RESP_OKAY);
    rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
    wr(`ADDR_EFFECT, 32'h7, `RESP_SLVERR);
    rd(4'h2, 32'h0, `RESP_SLVERR);
    $display("end regs");
  endtask
  // por beside a window watchdog event: both flagged
  task t_prio;
    @(posedge aclk);
    por_req <= 1;
    fire(3'h3, 8'h2);
    por_req <= 0;
    exp_rst(`EFF_POR, `INIT_FULL);
    rd(`ADDR_STATUS, 32'hA0, `RESP_OKAY);
    wr(`ADDR_STATUS, 32'hFF, `RESP_OKAY);
    rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
    $display("end prio");
  endtask
  task t_srcs;
    fire(3'h3, 8'h1);
    exp_rst(`EFF_WINWDT, `INIT_MOST);
    fire(3'h4, 8'h1);
    exp_rst(`EFF_WINWDT, `INIT_MOST);
    fire(3'h5, 8'h1);
    exp_rst(`EFF_SOFT, `INIT_SKIP);
    fire(3'h1, 8'h3);
    repeat (8) @(posedge aclk);
    rd(`ADDR_STATUS, 32'h30, `RESP_OKAY);
    sram_write_active <= 1;
    fire(3'h1, 8'h6);
    exp_rst(`EFF_PIN, `INIT_MOST);
    chk(seen_clr, 0);
    chk(boot_config, 3'h5);
    chk(pll_select, 1);
    chk(sram_byte_undefined, 1);
    {boot_pins, sram_write_active} <= 4'h4;
    wr(`ADDR_CTRL, 32'h3, `RESP_OKAY);
    exp_rst(`EFF_SOFT, `INIT_SKIP);
    chk(boot_config, 3'h5);
    rd(`ADDR_STATUS, 32'h78, `RESP_OKAY);
    wr(`ADDR_STATUS, 32'hFF, `RESP_OKAY);
    $display("end sources");
  endtask
  // stop keeps sram, sleep clears it, pin in power-save wakes
  task t_wake;
    {in_stop, wake_enable} <= 5'h11;
    fire(3'h2, 8'h1);
    exp_rst(`EFF_WAKE, `INIT_FULL);
    chk(seen_clr, 0);
    {in_stop, in_sleep} <= 2'h1;
    fire(3'h2, 8'h1);
    exp_rst(`EFF_WAKE, `INIT_FULL);
    chk(seen_clr, 1);
    rd(`ADDR_STATUS, 32'h6, `RESP_OKAY);
    // leave user mode so the last reset must not pick the pll
    wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    fire(3'h1, 8'h6);
    exp_rst(`EFF_WAKE, `INIT_FULL);
    chk(pll_select, 0);
    $display("end wake");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_prio;
    t_srcs;
    t_wake;
    complete_run;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run;
  end
endmodule
